// ===== core/srictl_defs.vh
// Constants for the system reset and interrupt controller.
// Assumes a 32-bit APB register port and a 16-bit CPU address space.
`ifndef SRICTL_DEFS_VH
`define SRICTL_DEFS_VH

// Register byte offsets.
`define SRICTL_CTRL_OFS 12'h000
`define SRICTL_EN_OFS 12'h004
`define SRICTL_FLAG_OFS 12'h008
`define SRICTL_STAT_OFS 12'h00C

// Control register fields.
`define SRICTL_CTRL_URGENT 0
`define SRICTL_CTRL_EDGE 1
`define SRICTL_CTRL_FULLRST 2
`define SRICTL_CTRL_INTERVAL 3

// Enable register fields.
`define SRICTL_EN_PIN 0
`define SRICTL_EN_OSC 1
`define SRICTL_EN_FLASH 2
`define SRICTL_EN_MASK_LO 8
`define SRICTL_EN_MASK_HI 15

// Flag register fields.
`define SRICTL_FL_PIN 0
`define SRICTL_FL_OSC 1
`define SRICTL_FL_FLASH 2
`define SRICTL_FL_PINRST 3
`define SRICTL_FL_POR 4
`define SRICTL_FL_WDT 5

// Status register fields.
`define SRICTL_ST_GIE 0
`define SRICTL_ST_STATE_LO 2
`define SRICTL_ST_STATE_HI 3
`define SRICTL_ST_OFF 4
`define SRICTL_ST_NMI 5

// Addresses and values.
`define SRICTL_RESET_VEC 16'hFFFE
`define SRICTL_NMI_VEC 16'hFFFC
`define SRICTL_MASK_VEC_TOP 16'hFFFA
`define SRICTL_BLANK_WORD 16'hFFFF
`define SRICTL_PERIPH_TOP 16'h01FF
`define SRICTL_ZERO32 32'h00000000

// Entry takes six cycles from acceptance to the first handler instruction.
`define SRICTL_ENTRY_CYC 3'h6
`define SRICTL_PUSH_PC_CYC 3'h1
`define SRICTL_PUSH_SR_CYC 3'h2

`endif

// ===== core/srictl_top.v
// System reset generation and interrupt gating with an APB register port.
// Assumes the CPU, memory and peripherals share clock_i; the dual-purpose
// pin, supply and oscillator inputs are asynchronous and are synchronised.
//
// Functional notes
// - Full reset from power, pin, supervisor.
// - Full reset always implies soft clear.
// - Soft clear from watchdog, keys, low fetch.
// - Full reset restores pin, io, status, watchdog.
// - Load reset vector; blank word powers off.
// - Fixed priority, lower slot wins.
// - Urgent sources ignore global enable.
// - Urgent acceptance clears all three enables.
// - Exactly three urgent request sources.
// - Pin function from control register urgent bit.
// - Pin low holds reset; rise sets flag.
// - Urgent edge sets flag, enable gates request.
// - Soft clear returns pin to reset mode.
// - Edge select change may fire in urgent.
// - Flash violation flag, gated by enable.
// - Oscillator fault flag, gated by enable.
// - Soft clear forces crystal modes off.
// - Per-source and global masking.
// - Maskable request needs both enables.
// - Six-cycle entry pushes PC then SR.
// - Watchdog interval flag auto-clears on acceptance.
// - Return restores saved status.
`timescale 1ns/1ps
`include "srictl_defs.vh"

module srictl_top (
    // Clock, reset and enable.
    input wire clock_i,
    input wire reset_i,
    input wire ce_i,
    // APB slave.
    input wire psel_i,
    input wire penable_i,
    input wire pwrite_i,
    input wire [11:0] paddr_i,
    input wire [31:0] pwdata_i,
    output wire [31:0] prdata_o,
    output wire pready_o,
    output wire pslverr_o,
    // Asynchronous system inputs.
    input wire power_up_i,
    input wire rst_urgent_pin_i,
    input wire supply_supervisor_low_i,
    input wire osc_fault_i,
    // Synchronous event inputs.
    input wire wdt_expire_i,
    input wire wdt_key_viol_i,
    input wire flash_key_viol_i,
    input wire flash_access_viol_i,
    input wire fetch_valid_i,
    input wire [15:0] fetch_addr_i,
    input wire [6:0] periph_irq_i,
    // CPU handshake.
    input wire irq_accept_i,
    input wire reti_i,
    input wire reti_gie_i,
    input wire [15:0] reset_word_i,
    output wire nmi_req_o,
    output wire irq_req_o,
    output wire [15:0] vector_addr_o,
    output wire pc_load_o,
    output wire push_pc_o,
    output wire push_sr_o,
    output wire global_irq_enable_o,
    output wire [7:0] irq_ack_o,
    // System outputs.
    output wire por_o,
    output wire soft_system_clear_o,
    output wire io_force_input_o,
    output wire lf_mode_force_o,
    output wire second_osc_off_o,
    output wire device_off_o
);

    localparam ST_IDLE = 2'b00;
    localparam ST_BOOT = 2'b01;
    localparam ST_ENTRY = 2'b10;

    // Picks the lowest pending slot; bit 3 marks a hit.
    function [3:0] pick;
        input [7:0] req;
        integer k;
        begin
            pick = 4'h0;
            for (k = 7; k >= 0; k = k - 1) begin
                if (req[k]) begin
                    pick = {1'b1, k[2:0]};
                end
            end
        end
    endfunction

    function [15:0] mask_vec;
        input [2:0] slot;
        begin
            mask_vec = `SRICTL_MASK_VEC_TOP - {12'h000, slot, 1'b0};
        end
    endfunction

    // Two-stage synchronisers for pin, supervisor, oscillator and power.
    reg [3:0] sync1_q;
    reg [3:0] sync2_q;
    reg pin_prev_q;
    reg lvl_prev_q;
    wire pin_s = sync2_q[0];
    wire sup_low_s = sync2_q[1];
    wire osc_s = sync2_q[2];
    wire pwr_s = sync2_q[3];

    reg [3:0] ctrl_q;
    reg [2:0] nmi_en_q;
    reg [7:0] mask_en_q;
    reg [5:0] flag_q;
    reg gie_q;
    reg [1:0] state_q;
    reg [2:0] cnt_q;
    reg nmi_sel_q;
    reg [2:0] slot_q;
    reg por_q;
    reg sc_q;
    reg off_q;
    reg nmi_req_q;
    reg irq_req_q;
    reg [15:0] vec_q;
    reg pc_load_q;
    reg push_pc_q;
    reg push_sr_q;
    reg [7:0] ack_q;
    reg [31:0] prdata_q;
    reg pready_q;
    reg pslverr_q;

    wire urgent = ctrl_q[`SRICTL_CTRL_URGENT];
    wire edge_sel = ctrl_q[`SRICTL_CTRL_EDGE];
    wire interval = ctrl_q[`SRICTL_CTRL_INTERVAL];

    // Full reset and soft clear sources.
    wire por_d = pwr_s | (~pin_s & ~urgent) |
        (sup_low_s & ctrl_q[`SRICTL_CTRL_FULLRST]);
    wire bad_fetch = fetch_valid_i & (fetch_addr_i <= `SRICTL_PERIPH_TOP);
    wire sc_d = por_d | (wdt_expire_i & ~interval) | wdt_key_viol_i |
        flash_key_viol_i | bad_fetch;

    // The edge detector compares the pin against the selected polarity,
    // so a polarity flip in urgent mode looks like an edge.
    wire lvl = pin_s ^ edge_sel;
    wire pin_event = urgent & lvl & ~lvl_prev_q;
    wire pin_rise = pin_s & ~pin_prev_q & ~urgent;

    wire [2:0] nmi_pend = flag_q[2:0] & nmi_en_q;
    wire nmi_any = |nmi_pend;
    wire [7:0] mask_src = {periph_irq_i, flag_q[`SRICTL_FL_WDT]};
    wire [7:0] mask_pend = mask_src & mask_en_q &
        {8{gie_q}};
    wire [3:0] hit = pick(mask_pend);
    wire take = irq_accept_i & (state_q == ST_IDLE) & ~sc_q &
        (nmi_any | hit[3]);

    // APB decode.
    wire apb_acc = psel_i & penable_i & ~pready_q;
    wire wr = apb_acc & pwrite_i;
    wire hit_ctrl = paddr_i == `SRICTL_CTRL_OFS;
    wire hit_en = paddr_i == `SRICTL_EN_OFS;
    wire hit_flag = paddr_i == `SRICTL_FLAG_OFS;
    wire hit_stat = paddr_i == `SRICTL_STAT_OFS;
    wire mapped = hit_ctrl | hit_en | hit_flag | hit_stat;

    reg [5:0] flag_set;
    reg [31:0] rd_word;

    always @* begin
        flag_set = 6'h00;
        flag_set[`SRICTL_FL_PIN] = pin_event;
        flag_set[`SRICTL_FL_OSC] = osc_s;
        flag_set[`SRICTL_FL_FLASH] = flash_access_viol_i;
        flag_set[`SRICTL_FL_PINRST] = pin_rise;
        flag_set[`SRICTL_FL_POR] = por_q;
        flag_set[`SRICTL_FL_WDT] = wdt_expire_i & interval;
    end

    always @* begin
        rd_word = `SRICTL_ZERO32;
        if (hit_ctrl) begin
            rd_word[3:0] = ctrl_q;
        end else if (hit_en) begin
            rd_word[2:0] = nmi_en_q;
            rd_word[`SRICTL_EN_MASK_HI:`SRICTL_EN_MASK_LO] = mask_en_q;
        end else if (hit_flag) begin
            rd_word[5:0] = flag_q;
        end else if (hit_stat) begin
            rd_word[`SRICTL_ST_GIE] = gie_q;
            rd_word[`SRICTL_ST_STATE_HI:`SRICTL_ST_STATE_LO] = state_q;
            rd_word[`SRICTL_ST_OFF] = off_q;
            rd_word[`SRICTL_ST_NMI] = nmi_any;
        end
    end

    // The synchronisers reset to the power-up state, so every release of
    // reset_i is followed by a full reset, and the oscillator fault flag is
    // set as a soft clear switching the crystals would set it.
    always @(posedge clock_i) begin
        if (reset_i) begin
            sync1_q <= 4'hF;
            sync2_q <= 4'hF;
            pin_prev_q <= 1'b1;
            lvl_prev_q <= 1'b1;
            por_q <= 1'b1;
            sc_q <= 1'b1;
        end else if (ce_i) begin
            sync1_q <= {power_up_i, osc_fault_i, supply_supervisor_low_i,
                rst_urgent_pin_i};
            sync2_q <= sync1_q;
            pin_prev_q <= pin_s;
            lvl_prev_q <= lvl;
            por_q <= por_d;
            sc_q <= sc_d | por_q;
        end
    end

    // Register file and interrupt state.
    always @(posedge clock_i) begin
        if (reset_i) begin
            ctrl_q <= 4'h0;
            nmi_en_q <= 3'h0;
            mask_en_q <= 8'h00;
            flag_q <= 6'h00;
            gie_q <= 1'b0;
        end else if (ce_i) begin
            if (sc_q) begin
                ctrl_q <= 4'h0;
                nmi_en_q <= 3'h0;
                mask_en_q <= 8'h00;
                gie_q <= 1'b0;
            end else begin
                if (wr & hit_ctrl) begin
                    ctrl_q <= pwdata_i[3:0];
                end
                if (take & nmi_any) begin
                    nmi_en_q <= 3'h0;
                end else if (wr & hit_en) begin
                    nmi_en_q <= pwdata_i[2:0];
                end
                if (wr & hit_en) begin
                    mask_en_q <= pwdata_i[
                        `SRICTL_EN_MASK_HI:`SRICTL_EN_MASK_LO];
                end
                if (take) begin
                    gie_q <= 1'b0;
                end else if (reti_i) begin
                    gie_q <= reti_gie_i;
                end else if (wr & hit_stat) begin
                    gie_q <= pwdata_i[`SRICTL_ST_GIE];
                end
            end
            // Write one to clear; a new event in the same cycle wins.
            flag_q <= (flag_q & ~((wr & hit_flag) ? pwdata_i[5:0] : 6'h00)
                & ~((take & ~nmi_any & hit[3] & (hit[2:0] == 3'h0)) ?
                6'h20 : 6'h00)) | flag_set;
        end
    end

    // Boot and entry sequencer.
    always @(posedge clock_i) begin
        if (reset_i) begin
            state_q <= ST_IDLE;
            cnt_q <= 3'h0;
            nmi_sel_q <= 1'b0;
            slot_q <= 3'h0;
            off_q <= 1'b0;
            vec_q <= `SRICTL_RESET_VEC;
            pc_load_q <= 1'b0;
            push_pc_q <= 1'b0;
            push_sr_q <= 1'b0;
            ack_q <= 8'h00;
            nmi_req_q <= 1'b0;
            irq_req_q <= 1'b0;
        end else if (ce_i) begin
            pc_load_q <= 1'b0;
            push_pc_q <= 1'b0;
            push_sr_q <= 1'b0;
            ack_q <= 8'h00;
            nmi_req_q <= nmi_any & ~sc_q;
            irq_req_q <= hit[3] & ~sc_q;
            if (sc_q) begin
                state_q <= sc_d ? ST_IDLE : ST_BOOT;
                cnt_q <= 3'h0;
                if (por_q) begin
                    off_q <= 1'b0;
                end
            end else begin
                case (state_q)
                    ST_BOOT: begin
                        vec_q <= `SRICTL_RESET_VEC;
                        if (reset_word_i == `SRICTL_BLANK_WORD) begin
                            off_q <= 1'b1;
                        end else begin
                            pc_load_q <= 1'b1;
                        end
                        state_q <= ST_IDLE;
                    end
                    ST_IDLE: begin
                        if (take) begin
                            nmi_sel_q <= nmi_any;
                            slot_q <= hit[2:0];
                            cnt_q <= 3'h0;
                            state_q <= ST_ENTRY;
                            if (~nmi_any) begin
                                ack_q[hit[2:0]] <= 1'b1;
                            end
                        end
                    end
                    ST_ENTRY: begin
                        cnt_q <= cnt_q + 3'h1;
                        push_pc_q <= cnt_q == `SRICTL_PUSH_PC_CYC;
                        push_sr_q <= cnt_q == `SRICTL_PUSH_SR_CYC;
                        if (cnt_q == `SRICTL_ENTRY_CYC - 3'h2) begin
                            vec_q <= nmi_sel_q ? `SRICTL_NMI_VEC :
                                mask_vec(slot_q);
                            pc_load_q <= 1'b1;
                            state_q <= ST_IDLE;
                        end
                    end
                    default: begin
                        state_q <= ST_IDLE;
                    end
                endcase
            end
        end
    end

    // APB answers after one wait state.
    always @(posedge clock_i) begin
        if (reset_i) begin
            prdata_q <= `SRICTL_ZERO32;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
        end else if (ce_i) begin
            pready_q <= apb_acc;
            pslverr_q <= apb_acc & ~mapped;
            if (apb_acc & ~pwrite_i) begin
                prdata_q <= rd_word;
            end
        end
    end

    assign prdata_o = prdata_q;
    assign pready_o = pready_q;
    assign pslverr_o = pslverr_q;
    assign nmi_req_o = nmi_req_q;
    assign irq_req_o = irq_req_q;
    assign vector_addr_o = vec_q;
    assign pc_load_o = pc_load_q;
    assign push_pc_o = push_pc_q;
    assign push_sr_o = push_sr_q;
    assign global_irq_enable_o = gie_q;
    assign irq_ack_o = ack_q;
    assign por_o = por_q;
    assign soft_system_clear_o = sc_q;
    assign io_force_input_o = por_q;
    assign lf_mode_force_o = sc_q;
    assign second_osc_off_o = sc_q;
    assign device_off_o = off_q;

endmodule // srictl_top

// ===== dv/srictl_sva.sv
// Port checker of the reset and interrupt controller.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
module srictl_sva (
    // Clock and reset.
    input wire clock_i,
    input wire reset_i,
    // Watched ports.
    input wire wdt_key_viol_i,
    input wire fetch_valid_i,
    input wire [15:0] fetch_addr_i,
    input wire por_o,
    input wire soft_system_clear_o,
    input wire io_force_input_o,
    input wire lf_mode_force_o,
    input wire second_osc_off_o,
    input wire push_pc_o,
    input wire push_sr_o,
    input wire pc_load_o,
    input wire [15:0] vector_addr_o,
    input wire [7:0] irq_ack_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (reset_i);
    property p_por_clear;
        por_o |-> soft_system_clear_o;
    endproperty
    a_por_clear: assert property (p_por_clear)
        else $error("full reset without soft clear");
    property p_fall_order;
        $fell(por_o) |-> soft_system_clear_o;
    endproperty
    a_fall_order: assert property (p_fall_order)
        else $error("soft clear ended with full reset");
    property p_io_input;
        io_force_input_o == por_o;
    endproperty
    a_io_input: assert property (p_io_input)
        else $error("io force differs from full reset");
    property p_osc_off;
        soft_system_clear_o |-> lf_mode_force_o && second_osc_off_o;
    endproperty
    a_osc_off: assert property (p_osc_off)
        else $error("crystal modes not forced");
    property p_key_clear;
        wdt_key_viol_i |-> ##[1:4] soft_system_clear_o;
    endproperty
    a_key_clear: assert property (p_key_clear)
        else $error("key violation gave no clear");
    property p_fetch_clear;
        fetch_valid_i && fetch_addr_i <= 16'h01FF
            |-> ##[1:4] soft_system_clear_o;
    endproperty
    a_fetch_clear: assert property (p_fetch_clear)
        else $error("low fetch gave no clear");
    property p_push_order;
        push_pc_o |=> push_sr_o;
    endproperty
    a_push_order: assert property (p_push_order)
        else $error("status push did not follow");
    property p_entry_load;
        push_sr_o |-> ##2 pc_load_o;
    endproperty
    a_entry_load: assert property (p_entry_load)
        else $error("vector load late");
    property p_ack_entry;
        irq_ack_o != 8'h00 |-> ##2 push_pc_o;
    endproperty
    a_ack_entry: assert property (p_ack_entry)
        else $error("flag clear without entry");
    c_urgent: cover property (pc_load_o && vector_addr_o == 16'hFFFC);
    c_entry: cover property (push_pc_o);
    c_release: cover property ($fell(por_o));
endmodule // srictl_sva
bind srictl_top srictl_sva u_sva (.clock_i, .reset_i, .wdt_key_viol_i,
    .fetch_valid_i, .fetch_addr_i, .por_o, .soft_system_clear_o,
    .io_force_input_o, .lf_mode_force_o, .second_osc_off_o, .push_pc_o,
    .push_sr_o, .pc_load_o, .vector_addr_o, .irq_ack_o);

// ===== dv/srictl_cpu_model.sv
// CPU partner: takes a pending request after a set delay, then waits.
// Assumes registered request levels and a vector load pulse.
`timescale 1ns/1ps
module srictl_cpu_model (
    // Clock and reset.
    input wire clock_i,
    input wire reset_i,
    // Delay before acceptance, in cycles.
    input wire [1:0] delay_i,
    // Controller handshake.
    input wire req_i,
    input wire pc_load_i,
    output reg accept_o
);
    reg busy_q;
    reg [1:0] wait_q;
    always @(posedge clock_i) begin
        accept_o <= !reset_i && req_i && !busy_q && wait_q == delay_i;
        wait_q <= (req_i && !busy_q && wait_q != delay_i) ? wait_q + 2'h1
            : 2'h0;
        // No second request is taken until the vector is loaded.
        busy_q <= !reset_i && (busy_q ? !pc_load_i : accept_o);
    end
endmodule // srictl_cpu_model

// ===== dv/srictl_top_tb.sv
// Self-checking bench of the reset and interrupt controller.
// Assumes the partner model and the bound checker are compiled first.
`timescale 1ns/1ps
module srictl_top_tb;
    reg clock_i, reset_i, psel_i, penable_i, pwrite_i, rst_urgent_pin_i;
    reg [11:0] paddr_i;
    reg [31:0] pwdata_i, seed, rd;
    reg [15:0] fetch_addr_i, reset_word_i;
    reg [6:0] periph_irq_i, p, act;
    reg [7:0] en;
    reg [5:0] kick;
    reg g;
    integer mismatches, compares, i, k;
    wire [31:0] prdata_o;
    wire [15:0] vector_addr_o;
    wire pready_o, pslverr_o, nmi_req_o, irq_req_o, pc_load_o, por_o;
    wire global_irq_enable_o, soft_system_clear_o, device_off_o;
    wire irq_accept_i;
    wire [3:0] watch = {device_off_o, pc_load_o, soft_system_clear_o, por_o};
    srictl_top uut (.clock_i, .reset_i, .ce_i(1'h1), .psel_i, .penable_i,
        .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o,
        .power_up_i(1'h0), .rst_urgent_pin_i, .supply_supervisor_low_i(1'h0),
        .osc_fault_i(kick[3]), .wdt_expire_i(kick[5]),
        .wdt_key_viol_i(kick[0]),
        .flash_key_viol_i(kick[1]), .flash_access_viol_i(kick[2]),
        .fetch_valid_i(kick[4]), .fetch_addr_i, .periph_irq_i, .irq_accept_i,
        .reti_i(1'h0), .reti_gie_i(1'h0), .reset_word_i, .nmi_req_o,
        .irq_req_o, .vector_addr_o, .pc_load_o, .push_pc_o(), .push_sr_o(),
        .global_irq_enable_o, .irq_ack_o(), .por_o, .soft_system_clear_o,
        .io_force_input_o(), .lf_mode_force_o(), .second_osc_off_o(),
        .device_off_o);
    srictl_cpu_model u_cpu (.clock_i, .reset_i, .delay_i(seed[1:0]),
        .req_i(nmi_req_o | irq_req_o), .pc_load_i(pc_load_o),
        .accept_o(irq_accept_i));
    function [31:0] lfsr(input [31:0] s);
        lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function [15:0] exp_vec(input [6:0] m);
        integer j;
        begin
            exp_vec = 16'h0000;
            for (j = 6; j >= 0; j = j - 1)
                if (m[j]) exp_vec = 16'hFFF8 - 16'(2 * j);
        end
    endfunction
    task chk(input [15:0] got, input [15:0] exp);
        begin
            compares = compares + 1;
            if (got !== exp) begin
                mismatches = mismatches + 1;
                $display("CHECK FAILED %0t: got %h want %h", $time, got, exp);
            end
        end
    endtask
    task tally_and_finish;
        begin
            $display("compares %0d mismatches %0d", compares, mismatches);
            if (mismatches == 0 && compares > 0) begin
                $display("NO MISMATCHES");
            end else begin
                $display("MISMATCHES SEEN");
            end
            $finish;
        end
    endtask
    task hang;
        begin
            mismatches = mismatches + 1;
            $display("CHECK FAILED %0t: wait ran out", $time);
            tally_and_finish;
        end
    endtask
    task wait_on(input [1:0] sel, input v);
        integer n;
        begin
            n = 0;
            do begin
                @(posedge clock_i);
                n = n + 1;
            end while (watch[sel] !== v && n < 300);
            if (watch[sel] !== v) hang;
        end
    endtask
    task apb(input w, input [11:0] a, input [31:0] d);
        integer n;
        begin
            @(posedge clock_i);
            psel_i <= 1'h1;
            pwrite_i <= w;
            paddr_i <= a;
            pwdata_i <= d;
            @(posedge clock_i);
            penable_i <= 1'h1;
            n = 0;
            do begin
                @(posedge clock_i);
                n = n + 1;
            end while (pready_o !== 1'h1 && n < 20);
            rd = prdata_o;
            psel_i <= 1'h0;
            penable_i <= 1'h0;
            if (pready_o !== 1'h1) hang;
        end
    endtask
    task fire(input [5:0] m);
        begin
            @(posedge clock_i);
            kick <= m;
            @(posedge clock_i);
            kick <= 6'h00;
        end
    endtask
    initial begin
        clock_i = 1'h0;
        forever #25 clock_i = ~clock_i;
    end
    initial begin
        {mismatches, compares, seed} = {32'h0, 32'h0, 32'h2D66};
        {reset_i, psel_i, penable_i, pwrite_i, rst_urgent_pin_i} = 5'h11;
        {paddr_i, pwdata_i, kick, fetch_addr_i, periph_irq_i} = 0;
        reset_word_i = 16'h1000;
        repeat (4) @(posedge clock_i);
        reset_i <= 1'h0;
        wait_on(0, 1'h0);
        wait_on(2, 1'h1);
        chk(vector_addr_o, 16'hFFFE);
        apb(0, 12'h010, 32'h0);
        chk({15'h0, pslverr_o}, 16'h1);
        $display("test boot done");
        for (i = 0; i < 8; i = i + 1) begin
            seed = lfsr(lfsr(lfsr(seed)));
            p = (i == 0) ? 7'h7F : seed[6:0];
            en = (i == 0) ? 8'hFF : seed[15:8];
            g = (i == 0) | ((i != 1) & seed[16]);
            act = p & en[7:1];
            apb(1, 12'h00C, 32'h0);
            periph_irq_i <= p;
            apb(1, 12'h004, {16'h0, en, 8'h00});
            apb(1, 12'h00C, {31'h0, g});
            if (g && act != 7'h00) begin
                wait_on(2, 1'h1);
                chk(vector_addr_o, exp_vec(act));
                chk({15'h0, global_irq_enable_o}, 16'h0);
            end else begin
                repeat (6) @(posedge clock_i);
                chk({15'h0, irq_req_o}, 16'h0);
            end
            periph_irq_i <= 7'h00;
        end
        $display("test maskable done");
        apb(1, 12'h00C, 32'h0);
        apb(1, 12'h008, 32'h3F);
        for (k = 0; k < 3; k = k + 1) begin
            apb(1, 12'h000, {30'h0, k == 0, k == 0});
            apb(1, 12'h004, 32'h1 << k);
            if (k == 0) begin
                rst_urgent_pin_i <= 1'h0;
                repeat (4) @(posedge clock_i);
                rst_urgent_pin_i <= 1'h1;
            end else fire(k == 1 ? 5'h08 : 5'h04);
            wait_on(2, 1'h1);
            chk(vector_addr_o, 16'hFFFC);
            apb(0, 12'h004, 32'h0);
            chk(rd[15:0], 16'h0000);
            apb(0, 12'h008, 32'h0);
            chk({15'h0, rd[k]}, 16'h1);
            apb(1, 12'h008, 32'h1 << k);
        end
        fire(5'h04);
        repeat (6) @(posedge clock_i);
        chk({15'h0, nmi_req_o}, 16'h0);
        apb(0, 12'h008, 32'h0);
        chk({15'h0, rd[2]}, 16'h1);
        $display("test urgent done");
        for (k = 0; k < 6; k = k + 1) begin
            apb(1, 12'h000, (k == 5) ? 32'h9 : 32'h1);
            fetch_addr_i <= (k == 3) ? 16'h0200 : 16'h01FF;
            fire(k == 0 ? 6'h01 : k == 1 ? 6'h02 : k >= 4 ? 6'h20 : 6'h10);
            if (k == 3 || k == 5) begin
                repeat (4) @(posedge clock_i);
                chk({15'h0, soft_system_clear_o}, 16'h0);
            end else begin
                wait_on(1, 1'h1);
                chk({15'h0, por_o}, 16'h0);
                wait_on(2, 1'h1);
                apb(0, 12'h000, 32'h0);
                chk(rd[15:0], 16'h0000);
            end
        end
        apb(0, 12'h008, 32'h0);
        chk({15'h0, rd[5]}, 16'h1);
        $display("test soft clear done");
        apb(1, 12'h000, 32'h0);
        rst_urgent_pin_i <= 1'h0;
        wait_on(0, 1'h1);
        repeat (5) @(posedge clock_i);
        chk({15'h0, por_o}, 16'h1);
        reset_word_i <= 16'hFFFF;
        rst_urgent_pin_i <= 1'h1;
        wait_on(3, 1'h1);
        chk({15'h0, device_off_o}, 16'h1);
        apb(0, 12'h008, 32'h0);
        chk({15'h0, rd[3]}, 16'h1);
        $display("test pin reset done");
        tally_and_finish;
    end
endmodule // srictl_top_tb
